// File: rate_ref_cfg.svh
// named constants of the ramped rate reference controller
// assumes a 10 MHz clock; rates in units of 0.01 Hz fundamental
`ifndef RATE_REF_CFG_SVH
`define RATE_REF_CFG_SVH
// ------------------------------------------------------------
// clock and time base
// ------------------------------------------------------------
`define CLK_HZ        10_000_000
`define TICK_US       10
`define TICK_CYC      (`CLK_HZ / 1_000_000 * `TICK_US)
`define DS_US         100_000
`define DS_TICKS      26'(`DS_US / `TICK_US)
`define PULSE_W_US    50
`define PULSE_W_CYC   10'(`CLK_HZ / 1_000_000 * `PULSE_W_US)
// ------------------------------------------------------------
// rates, intervals and ranges
// ------------------------------------------------------------
`define MIN_RATE      16'h009B
`define RATE_LO       17'h0_009C
`define RATE_HI       17'h0_C350
`define IVL_LO        17'h0_07D0
`define IVL_HI        17'h0_FFFF
`define SPAN_60       26'h000_1770
`define PULSES_PER_F  19'h0_0006
`define PULSE_NUM     30'h3B9A_CA00
`define DIV_NUM       27'h5F5_E100
`define DIV_STEPS     5'h1B
`define DIGITS_RATE   3'h5
`define DIGITS_IVL    3'h5
`define DIGITS_RAMP   3'h2
`define DIGITS_MULT   3'h4
// ------------------------------------------------------------
// reset values of the settings
// ------------------------------------------------------------
`define RST_RATE      16'h1770
`define RST_IVL       16'h411B
`define RST_RAMP      7'h37
`define RST_MULT      16'h03E8
`endif

// File: rate_ref_pkg.sv
// types shared by the ramped rate reference controller
// assumes rate_ref_cfg.svh supplies the numeric constants
package rate_ref_pkg;
  typedef enum logic [3:0] {
    K_0, K_1, K_2, K_3, K_4, K_5, K_6, K_7, K_8, K_9,
    K_RATE, K_IVL, K_UP, K_DOWN, K_MULT, K_CONFIRM
  } key_code_t;
  typedef struct packed {
    logic      valid;
    key_code_t code;
  } key_t;
  typedef enum logic [2:0] {F_RATE, F_IVL, F_UP, F_DOWN, F_MULT} field_t;
  typedef enum logic [2:0] {
    SHOW_BLANK, SHOW_VALUE, SHOW_ENTRY, SHOW_PRESENT, SHOW_ERROR
  } disp_mode_t;
  typedef struct packed {
    disp_mode_t  mode;
    field_t      field;
    logic [16:0] value;
    logic [2:0]  entered;
    logic [2:0]  bars;
    logic        rejected;
  } display_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DIGITS = 3'b010,
    ST_DIVIDE = 3'b100
  } entry_state_t;
endpackage : rate_ref_pkg

// File: ramped_rate_reference_ctrl.sv
// ramped rate reference: keypad setpoints, linear ramp, 6x pulse train
// assumes keys arrive as one-cycle strobes synchronous to clk
`timescale 1ns/1ps
`include "rate_ref_cfg.svh"

// Functional notes
// - ramp setting 00..99 maps to 2.1..518.0 s for a 60 Hz span
// - ramp time scales in proportion to the size of the rate change
// - interval entries 02.000..65.535 ms accepted in interval mode
// - interval accepted only if its rate is below the upper rate limit
// - interval key is refused when the block runs in rate mode
// - interval shown in ms of fundamental; pulses come six times faster
// - with run asked and no freeze, ramp toward the new target
// - in interval mode the interval key shows the stored interval first
// - four-digit multiplier 0.000..9.999 can be shown and entered
// - multiplier key accepted only as the first key of a sequence
// - freeze keeps pulse rate and drive enable unchanged
// - after freeze release with run asked, ramp up at ramp-up rate
// - after freeze release with run not asked, ramp down to stop
// - while freeze is held the present rate is kept
// - run request changes are ignored while freeze is closed
// - run request closing energizes drive enable and ramps up
// - run request opening ramps down; drive enable drops at minimum
// - output pulses run at six times the fundamental rate
// - stopped condition keeps pulses at 1.55 Hz fundamental
// - digits fill from the left; bars mark digits still awaited
// - confirm blanks display, or shows present rate while ramping
module ramped_rate_reference_ctrl
  import rate_ref_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        interval_mode,
  input  wire logic        run_request,
  input  wire logic        freeze,
  input  wire logic [15:0] rate_limit,
  input  wire key_t        key,
  output logic             pulse_out,
  output logic             drive_enable,
  output logic             ramping,
  output logic [15:0]      present_rate,
  output logic [29:0]      multiplied_rate_readout,
  output display_t         disp
);

  // ------------------------------------------------------------
  // ramp time table, in tenths of a second
  // ------------------------------------------------------------
  function automatic logic [12:0] ramp_ds(input logic [6:0] s);
    logic [12:0] v;
    v = 13'h0015;
    if (s < 7'h20) v = 13'h0015 + 13'(s);
    else if (s < 7'h38) v = 13'h0036 + 13'({s - 7'h20, 1'b0});
    else if (s < 7'h48) v = 13'h0069 + 13'(s - 7'h38) * 13'h0005;
    else begin
      case (s)
        7'h48: v = 13'h00BE;  7'h49: v = 13'h00C3;  7'h4A: v = 13'h00C8;
        7'h4B: v = 13'h00D2;  7'h4C: v = 13'h00DC;  7'h4D: v = 13'h00E6;
        7'h4E: v = 13'h00F0;  7'h4F: v = 13'h00FA;  7'h50: v = 13'h0104;
        7'h51: v = 13'h0113;  7'h52: v = 13'h0122;  7'h53: v = 13'h0136;
        7'h54: v = 13'h014A;  7'h55: v = 13'h015E;  7'h56: v = 13'h0177;
        7'h57: v = 13'h0190;  7'h58: v = 13'h01B3;  7'h59: v = 13'h01E0;
        7'h5A: v = 13'h020D;  7'h5B: v = 13'h0249;  7'h5C: v = 13'h028F;
        7'h5D: v = 13'h02EE;  7'h5E: v = 13'h0384;  7'h5F: v = 13'h03FC;
        7'h60: v = 13'h0500;  7'h61: v = 13'h06A4;  7'h62: v = 13'h0A14;
        default: v = 13'h143C;
      endcase
    end
    return v;
  endfunction : ramp_ds

  function automatic logic [2:0] digits_of(input field_t f);
    case (f)
      F_RATE:  return `DIGITS_RATE;
      F_IVL:   return `DIGITS_IVL;
      F_MULT:  return `DIGITS_MULT;
      default: return `DIGITS_RAMP;
    endcase
  endfunction : digits_of

  entry_state_t state;
  field_t       field;
  disp_mode_t   disp_mode;
  logic [16:0]  entry_val;
  logic [16:0]  shown_val;
  logic [2:0]   entered;
  logic         rejected;
  logic [15:0]  target_rate;
  logic [15:0]  target_ivl;
  logic [15:0]  mult;
  logic [6:0]   ramp_up;
  logic [6:0]   ramp_down;
  logic [16:0]  rem;
  logic [26:0]  num;
  logic [15:0]  quo;
  logic [4:0]   div_cnt;
  logic [15:0]  rate;
  logic [15:0]  goal;
  logic [25:0]  ramp_acc;
  logic [15:0]  tick_cnt;
  logic [29:0]  phase;
  logic [9:0]   width_cnt;
  logic         is_digit;
  logic [16:0]  trial;
  logic [16:0]  next_val;

  assign is_digit = key.code <= K_9;
  assign next_val = 17'(entry_val * 17'h0_000A) + 17'(key.code);
  assign trial    = {rem[15:0], num[26]};
  assign goal     = run_request ? target_rate : `MIN_RATE;
  assign ramping  = rate != goal;

  // ------------------------------------------------------------
  // keypad entry and setpoint storage
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      field       <= F_RATE;
      disp_mode   <= SHOW_BLANK;
      entry_val   <= '0;
      shown_val   <= '0;
      entered     <= '0;
      rejected    <= 1'b0;
      target_rate <= `RST_RATE;
      target_ivl  <= `RST_IVL;
      mult        <= `RST_MULT;
      ramp_up     <= `RST_RAMP;
      ramp_down   <= `RST_RAMP;
      rem         <= '0;
      num         <= '0;
      quo         <= '0;
      div_cnt     <= '0;
    end else if (ce) begin
      case (state)
        ST_IDLE: if (key.valid) begin
          rejected <= 1'b0;
          entry_val <= '0;
          entered <= '0;
          if (is_digit || key.code == K_CONFIRM) begin
            disp_mode <= SHOW_ERROR;
          end else if (key.code == K_IVL && !interval_mode) begin
            disp_mode <= SHOW_ERROR;
          end else if (key.code == K_RATE && interval_mode) begin
            disp_mode <= SHOW_ERROR;
          end else begin
            state <= ST_DIGITS;
            disp_mode <= SHOW_VALUE;
            case (key.code)
              K_RATE: begin
                field <= F_RATE;
                shown_val <= {1'b0, target_rate};
              end
              K_IVL: begin
                field <= F_IVL;
                shown_val <= {1'b0, target_ivl};
              end
              K_UP: begin
                field <= F_UP;
                shown_val <= {10'h000, ramp_up};
              end
              K_DOWN: begin
                field <= F_DOWN;
                shown_val <= {10'h000, ramp_down};
              end
              default: begin
                field <= F_MULT;
                shown_val <= {1'b0, mult};
              end
            endcase
          end
        end
        ST_DIGITS: if (key.valid) begin
          if (is_digit && entered != digits_of(field)) begin
            entry_val <= next_val;
            shown_val <= next_val;
            entered <= entered + 3'h1;
            disp_mode <= SHOW_ENTRY;
          end else if (key.code == K_CONFIRM && entered == digits_of(field)) begin
            state <= ST_IDLE;
            disp_mode <= ramping ? SHOW_PRESENT : SHOW_BLANK;
            case (field)
              F_RATE: if (entry_val >= `RATE_LO && entry_val <= `RATE_HI &&
                           entry_val < {1'b0, rate_limit}) begin
                target_rate <= entry_val[15:0];
              end else begin
                rejected <= 1'b1;
                disp_mode <= SHOW_ERROR;
              end
              F_IVL: if (entry_val >= `IVL_LO && entry_val <= `IVL_HI) begin
                state <= ST_DIVIDE;
                rem <= '0;
                num <= `DIV_NUM;
                quo <= '0;
                div_cnt <= `DIV_STEPS;
              end else begin
                rejected <= 1'b1;
                disp_mode <= SHOW_ERROR;
              end
              F_UP:   ramp_up <= entry_val[6:0];
              F_DOWN: ramp_down <= entry_val[6:0];
              default: mult <= entry_val[15:0];
            endcase
          end else begin
            // too many digits, early confirm or a second select key
            state <= ST_IDLE;
            disp_mode <= SHOW_ERROR;
          end
        end
        ST_DIVIDE: begin
          num <= {num[25:0], 1'b0};
          if (trial >= entry_val) begin
            rem <= trial - entry_val;
            quo <= {quo[14:0], 1'b1};
          end else begin
            rem <= trial;
            quo <= {quo[14:0], 1'b0};
          end
          div_cnt <= div_cnt - 5'h01;
          if (div_cnt == 5'h00) begin
            state <= ST_IDLE;
            if (quo < rate_limit) begin
              target_rate <= quo;
              target_ivl <= entry_val[15:0];
            end else begin
              rejected <= 1'b1;
              disp_mode <= SHOW_ERROR;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // linear ramp of the fundamental rate
  // ------------------------------------------------------------
  logic [25:0] thr;
  logic [25:0] acc_sum;
  assign thr = 26'(ramp_ds(rate < goal ? ramp_up : ramp_down)) * `DS_TICKS;
  assign acc_sum = ramp_acc + `SPAN_60;

  always_ff @(posedge clk) begin
    if (reset) begin
      rate         <= `MIN_RATE;
      drive_enable <= 1'b0;
      ramp_acc     <= '0;
      tick_cnt     <= '0;
    end else if (ce && !freeze) begin
      if (run_request) drive_enable <= 1'b1;
      else if (rate == `MIN_RATE) drive_enable <= 1'b0;
      tick_cnt <= (tick_cnt == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      if (!ramping) begin
        ramp_acc <= '0;
      end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
        if (acc_sum >= thr) begin
          ramp_acc <= acc_sum - thr;
          rate <= (rate < goal) ? rate + 16'h0001 : rate - 16'h0001;
        end else begin
          ramp_acc <= acc_sum;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pulse train at six times the fundamental
  // ------------------------------------------------------------
  logic [29:0] phase_sum;
  assign phase_sum = phase + 30'(19'(rate) * `PULSES_PER_F);

  always_ff @(posedge clk) begin
    if (reset) begin
      phase     <= '0;
      width_cnt <= '0;
    end else if (ce) begin
      if (phase_sum >= `PULSE_NUM) begin
        phase <= phase_sum - `PULSE_NUM;
        width_cnt <= `PULSE_W_CYC;
      end else begin
        phase <= phase_sum;
        if (width_cnt != 10'h000) width_cnt <= width_cnt - 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) multiplied_rate_readout <= '0;
    else if (ce) multiplied_rate_readout <= 30'(rate) * 30'(mult[13:0]);
  end

  // active-high pulse; the inverting buffer sits outside this block
  assign pulse_out    = width_cnt != 10'h000;
  assign present_rate = rate;
  assign disp.mode     = disp_mode;
  assign disp.field    = field;
  assign disp.value    = (disp_mode == SHOW_PRESENT) ? {1'b0, rate} : shown_val;
  assign disp.entered  = entered;
  assign disp.bars     = (disp_mode == SHOW_ENTRY) ? digits_of(field) - entered : 3'h0;
  assign disp.rejected = rejected;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_relay_drop_min: assert property (@(posedge clk) disable iff (reset)
    $fell(drive_enable) |-> $past(rate) == `MIN_RATE && !$past(run_request))
    else $error("drive enable dropped above minimum rate");
  a_freeze_keeps: assert property (@(posedge clk) disable iff (reset)
    freeze |=> $stable(rate) && $stable(drive_enable))
    else $error("state moved during freeze");
  a_rate_step_one: assert property (@(posedge clk) disable iff (reset)
    ##1 (rate == $past(rate) || rate == $past(rate) + 16'h0001 ||
         rate == $past(rate) - 16'h0001))
    else $error("rate jumped by more than one step");
  a_rate_floor: assert property (@(posedge clk) disable iff (reset)
    rate >= `MIN_RATE)
    else $error("rate fell below minimum");
  a_run_energize: assert property (@(posedge clk) disable iff (reset)
    ce && !freeze && run_request |=> drive_enable)
    else $error("drive enable not set on run request");
  a_ivl_refused: assert property (@(posedge clk) disable iff (reset)
    ce && key.valid && state == ST_IDLE && key.code == K_IVL && !interval_mode
    |=> disp_mode == SHOW_ERROR && state == ST_IDLE)
    else $error("interval key taken in rate mode");
  a_pulse_width: assert property (@(posedge clk) disable iff (reset)
    $rose(pulse_out) |-> pulse_out[*8])
    else $error("pulse too short");
  a_target_limit: assert property (@(posedge clk) disable iff (reset)
    $changed(target_rate) |-> target_rate < $past(rate_limit))
    else $error("target stored above rate limit");
  a_reject_keeps: assert property (@(posedge clk) disable iff (reset)
    $rose(rejected) |-> $stable(target_rate) && $stable(target_ivl))
    else $error("rejected entry altered a setpoint");
endmodule : ramped_rate_reference_ctrl

// File: rr_contacts_model.sv
// far-side model: run and hold contacts plus the driven drive system
// assumes the bench sets want_run and want_hold just after a rising edge
`timescale 1ns/1ps
module rr_contacts_model (
  input  wire logic clk,
  input  wire logic want_run,
  input  wire logic want_hold,
  input  wire logic drive_enable,
  input  wire logic pulse_out,
  output logic      run_request,
  output logic      freeze,
  output int        pulses_seen
);
  // ------------------------------------------------------------
  // contacts
  // ------------------------------------------------------------
  // one flop of delay, as an input buffer would give; closed contact = 1
  initial begin
    run_request = 1'b0;
    freeze      = 1'b0;
    pulses_seen = 0;
  end
  always @(posedge clk) begin
    run_request <= want_run;
    freeze      <= want_hold;
  end
  // ------------------------------------------------------------
  // drive system
  // ------------------------------------------------------------
  // the drive only follows pulses while its enable relay is picked up
  always @(posedge clk) begin
    if (drive_enable && pulse_out) begin
      pulses_seen <= pulses_seen + 1;
    end
  end
endmodule : rr_contacts_model

// File: tb_ramped_rate_reference_ctrl.sv
// self-checking bench for the ramped rate reference controller
// assumes TICK_CYC=1 so that full ramps fit in a short run
`timescale 1ns/1ps
`include "rate_ref_cfg.svh"
module tb_ramped_rate_reference_ctrl import rate_ref_pkg::*;;
  // setting 00 is 2.1 s per 6000 counts, so 6000 per tick steps once in 35 ticks
  localparam int STEP_CYC = 35;
  logic        clk, reset, ce, interval_mode, want_run, want_hold;
  logic        run_request, freeze, pulse_out, drive_enable, ramping;
  logic [15:0] rate_limit, present_rate;
  logic [29:0] multiplied_rate_readout;
  key_t        key;
  display_t    disp;
  int          errors, n_tests, pulses_seen, tgt, cyc, t, wid, n_drive;
  longint      ph;
  int          sto [16];

`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got); end end

  ramped_rate_reference_ctrl #(.TICK_CYC(1)) u_dut (
    .clk(clk), .reset(reset), .ce(ce), .interval_mode(interval_mode),
    .run_request(run_request), .freeze(freeze), .rate_limit(rate_limit), .key(key),
    .pulse_out(pulse_out), .drive_enable(drive_enable), .ramping(ramping),
    .present_rate(present_rate), .multiplied_rate_readout(multiplied_rate_readout),
    .disp(disp));

  rr_contacts_model u_far (
    .clk(clk), .want_run(want_run), .want_hold(want_hold), .drive_enable(drive_enable),
    .pulse_out(pulse_out), .run_request(run_request), .freeze(freeze),
    .pulses_seen(pulses_seen));

  // pulse model: six times the reported fundamental into a 1e9 phase, 50 us high per pulse
  always @(posedge clk) begin
    if (!reset) `CHK("pulse train", wid != 0, pulse_out)
    if (drive_enable && wid != 0) n_drive++;
    if (reset) begin
      ph = 0;
      wid = 0;
    end else if (ce) begin
      ph += 6 * present_rate;
      if (ph >= `PULSE_NUM) begin
        ph -= `PULSE_NUM;
        wid = `PULSE_W_CYC;
      end else if (wid != 0) begin
        wid--;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic press(input key_code_t c);
    @(posedge clk) key <= {1'b1, c};
    @(posedge clk) key <= '0;
    #1;
  endtask : press

  task automatic refuse(input key_code_t c);
    press(c);
    `CHK("refused key", SHOW_ERROR, disp.mode)
  endtask : refuse

  // select, n digits from the left, confirm; fin is the display expected after confirm
  task automatic enter(input key_code_t sel, input int val, input int n, input disp_mode_t fin);
    int d;
    press(sel);
    `CHK("select mode", SHOW_VALUE, disp.mode)
    `CHK("stored value", sto[sel], disp.value)
    for (int i = 0; i < n; i++) begin
      d = (val / (10 ** (n - 1 - i))) % 10;
      press(key_code_t'(d));
      `CHK("digits keyed", i + 1, disp.entered)
      `CHK("bars left", n - 1 - i, disp.bars)
    end
    press(K_CONFIRM);
    // interval entries pass through the divider before they settle
    if (sel == K_IVL) repeat (30) @(posedge clk);
    #1;
    `CHK("rejected flag", fin == SHOW_ERROR, disp.rejected)
    `CHK("confirm display", fin, disp.mode)
    if (fin != SHOW_ERROR) sto[sel] = val;
  endtask : enter

  task automatic wait_rate(input int target, output int n);
    n = 0;
    while (present_rate !== 16'(target) && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_rate

  // span of a ramp in cycles must sit near counts times the step spacing
  task automatic chk_span(input int counts, input int n);
    `CHK("ramp span", 1, (n > counts * STEP_CYC - 60) && (n < counts * STEP_CYC + 40))
  endtask : chk_span

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    void'($urandom(10));
    reset = 1'b1;
    ce = 1'b1;
    interval_mode = 1'b0;
    want_run = 1'b0;
    want_hold = 1'b0;
    rate_limit = 16'hC350;
    key = '0;
    sto[K_RATE] = `RST_RATE;
    sto[K_IVL] = `RST_IVL;
    sto[K_UP] = `RST_RAMP;
    sto[K_DOWN] = `RST_RAMP;
    sto[K_MULT] = `RST_MULT;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("reset rate", `MIN_RATE, present_rate)
    `CHK("reset relay", 0, drive_enable)
    `CHK("reset display", SHOW_BLANK, disp.mode)
    tgt = 170 + ($urandom % 80);
    // ------------------------------------------------------------
    // keypad sequences
    // ------------------------------------------------------------
    enter(K_UP, 0, 2, SHOW_BLANK);
    enter(K_DOWN, 0, 2, SHOW_BLANK);
    enter(K_RATE, 100, 5, SHOW_ERROR);
    enter(K_RATE, tgt, 5, SHOW_BLANK);
    enter(K_MULT, 2500, 4, SHOW_BLANK);
    // the readout register trails the stored multiplier by one cycle
    @(posedge clk);
    #1;
    `CHK("readout", 155 * 2500, multiplied_rate_readout)
    refuse(K_3);
    press(K_RATE);
    refuse(K_CONFIRM);
    press(K_UP);
    refuse(K_MULT);
    refuse(K_IVL);
    press(K_RATE);
    repeat (5) press(K_1);
    refuse(K_1);
    // ------------------------------------------------------------
    // run, freeze and stop
    // ------------------------------------------------------------
    @(posedge clk) want_run <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("relay on run", 1, drive_enable)
    enter(K_MULT, 2500, 4, SHOW_PRESENT);
    wait_rate(tgt, cyc);
    chk_span(tgt - 155, cyc + 16);
    `CHK("settled", 0, ramping)
    @(posedge clk);
    #1;
    `CHK("readout at target", tgt * 2500, multiplied_rate_readout)
    @(posedge clk) want_run <= 1'b0;
    repeat (200) @(posedge clk);
    want_hold <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t = present_rate;
    `CHK("moved down", 1, t < tgt)
    repeat (300) @(posedge clk);
    #1;
    `CHK("frozen rate", t, present_rate)
    `CHK("frozen relay", 1, drive_enable)
    @(posedge clk) want_hold <= 1'b0;
    wait_rate(155, cyc);
    chk_span(t - 155, cyc);
    `CHK("relay at minimum", 1, drive_enable)
    repeat (2) @(posedge clk);
    #1;
    `CHK("relay off", 0, drive_enable)
    @(posedge clk) want_hold <= 1'b1;
    @(posedge clk) want_run <= 1'b1;
    repeat (50) @(posedge clk);
    #1;
    `CHK("run ignored", 0, drive_enable)
    `CHK("rate held", 155, present_rate)
    @(posedge clk) want_hold <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("relay after release", 1, drive_enable)
    wait_rate(tgt, cyc);
    chk_span(tgt - 155, cyc + 3);
    @(posedge clk) want_run <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1;
    t = present_rate;
    repeat (80) @(posedge clk);
    #1;
    `CHK("clock enable hold", t, present_rate)
    @(posedge clk) ce <= 1'b1;
    wait_rate(155, cyc);
    repeat (3) @(posedge clk);
    // ------------------------------------------------------------
    // interval configuration
    // ------------------------------------------------------------
    interval_mode <= 1'b1;
    enter(K_IVL, 2000, 5, SHOW_ERROR);
    @(posedge clk) rate_limit <= 16'hC351;
    enter(K_IVL, 1999, 5, SHOW_ERROR);
    enter(K_IVL, 2000, 5, SHOW_BLANK);
    enter(K_IVL, 65535, 5, SHOW_BLANK);
    press(K_IVL);
    `CHK("interval shown", 65535, disp.value)
    `CHK("drive pulses", n_drive, pulses_seen)
    conclude();
  end
endmodule : tb_ramped_rate_reference_ctrl
